// ==== shared/tcs_map.svh ====
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// Parity generators, top degree implied, one bit per lower degree
`define TCS_POLY24      24'h800063
`define TCS_POLY16      24'h001021
`define TCS_POLY12      24'h00080f
`define TCS_POLY8       24'h00009b
`define TCS_MASK24      24'hffffff
`define TCS_MASK16      24'h00ffff
`define TCS_MASK12      24'h000fff
`define TCS_MASK8       24'h0000ff

// Parity lengths in bits
`define TCS_LEN24       5'd24
`define TCS_LEN16       5'd16
`define TCS_LEN12       5'd12
`define TCS_LEN8        5'd8

// Largest code block sizes
`define TCS_ZMAX_CONV   25'd504
`define TCS_ZMAX_TURBO  25'd5114

// Encoder tail length, constraint length minus one
`define TCS_TAIL_LEN    25'd8

// Interval timing
`define TCS_TTI_BASE_MS 10
`define TCS_CLK_MHZ     100

`endif

// ==== shared/tcs_pkg.sv ====
package tcs_pkg;

   // Parity length selection
   typedef enum logic [2:0] {CRC_NONE, CRC_8, CRC_12, CRC_16, CRC_24} tcs_crc_t;

   // Channel coding selection
   typedef enum logic [1:0] {CODE_NONE, CODE_CONV_HALF, CODE_CONV_THIRD, CODE_TURBO} tcs_code_t;

   // Interval length selection: 10, 20, 40 or 80 ms
   typedef enum logic [1:0] {TTI_10, TTI_20, TTI_40, TTI_80} tcs_tti_t;

endpackage : tcs_pkg

// ==== core/tcs_core.sv ====
`include "tcs_map.svh"

// Shift-register FIFO, head entry is a flop
module tcs_fifo #(
   parameter int W = 1,
   parameter int D = 4
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Fill side
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   // Drain side
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int CW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [CW:0]  cnt;
   logic [CW:0]  wr_idx;
   logic [CW:0]  next_cnt;
   logic         push;
   logic         pop;

   // Handshakes
   assign in_ready_o = (cnt < (CW+1)'(D));
   assign push       = in_valid_i && in_ready_o;
   assign pop        = out_valid_o && out_ready_i;
   assign wr_idx     = pop ? cnt - 1'b1 : cnt;
   assign next_cnt   = cnt + (CW+1)'(push) - (CW+1)'(pop);
   assign out_data_o = mem[0];

   // Occupancy and flopped valid
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt         <= '0;
         out_valid_o <= 1'b0;
      end else begin
         cnt         <= next_cnt;
         out_valid_o <= (next_cnt != '0);
      end
   end

   // One storage entry each, shifting toward the head
   for (genvar i = 0; i < D; i++) begin : g_ent
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            mem[i] <= '0;
         end else if (push && wr_idx == (CW+1)'(i)) begin
            mem[i] <= in_data_i;
         end else if (pop) begin
            if (i < D-1) begin
               mem[i] <= mem[(i < D-1) ? i+1 : i];
            end else begin
               mem[i] <= '0;
            end
         end
      end
   end
endmodule : tcs_fifo

module tcs_core
   import tcs_pkg::*;
#(
   parameter int        A_W            = 16,
   parameter int        M_W            = 8,
   parameter int        FIFO_DEPTH     = 4,
   parameter int        TTI_BASE_CYC   = `TCS_TTI_BASE_MS * 1000 * `TCS_CLK_MHZ,
   parameter logic [8:0] GEN0          = 9'h16f,
   parameter logic [8:0] GEN1          = 9'h1d9,
   parameter logic [8:0] GEN2          = 9'h127
) (
   // Clock and reset
   input  wire logic             MCLK_I,
   input  wire logic             RSTN_I,
   // Interval configuration and start
   input  wire logic             START_I,
   input  wire tcs_pkg::tcs_tti_t TTI_SEL_I,
   input  wire tcs_pkg::tcs_crc_t CRC_SEL_I,
   input  wire tcs_pkg::tcs_code_t CODE_SEL_I,
   input  wire logic             CHAN_COMMON_I,
   input  wire logic [A_W-1:0]   BLK_LEN_I,
   input  wire logic [M_W-1:0]   BLK_CNT_I,
   // Transport block bits in
   input  wire logic             DIN_I,
   input  wire logic             DIN_VALID_I,
   output logic                  DIN_READY_O,
   // Coded bits out
   output logic                  DOUT_O,
   output logic                  DOUT_VALID_O,
   input  wire logic             DOUT_READY_I,
   // Status
   output logic                  BUSY_O,
   output logic                  DONE_O,
   output logic                  START_REJ_O
);
   import tcs_pkg::*;

   localparam int XW = 25;
   localparam int TW = 27;

   typedef enum {ST_IDLE, ST_CNT_C, ST_CNT_K, ST_RUN} tcs_state_t;

   tcs_state_t       state;
   tcs_code_t        code;
   logic [4:0]       par_len;
   logic [23:0]      poly;
   logic [23:0]      mask;
   logic [XW-1:0]    a_len;
   logic [XW-1:0]    b_len;
   logic [XW-1:0]    x_len;
   logic [XW-1:0]    z_max;
   logic             z_unlim;
   logic [XW-1:0]    c_num;
   logic [XW-1:0]    k_len;
   logic [XW-1:0]    acc;
   logic [TW-1:0]    tmr;
   logic [XW-1:0]    cb_pos;
   logic [XW-1:0]    cb_num;
   logic [XW-1:0]    cat_pos;
   logic [XW-1:0]    blk_bit;
   logic [23:0]      crc;
   logic [7:0]       sr;
   logic             cur;
   logic             have_bit;
   logic             last_bit;
   logic [1:0]       sub;
   logic             din_rdy;
   logic             busy;
   logic             done;
   logic             start_rej;
   logic             accept;
   logic             conv;
   logic [XW-1:0]    tail;
   logic             in_block;
   logic             in_cat;
   logic             want_data;
   logic             fetch_go;
   logic             fetch_bit;
   logic             cb_end;
   logic [1:0]       n_out;
   logic             emit;
   logic             emit_last;
   logic             enc_bit;
   logic             f_ready;
   logic [8:0]       taps;
   tcs_code_t        next_code;

   // Interval start gate
   assign accept = START_I && state == ST_IDLE && tmr == '0;

   // Common channels are held to convolutional half rate
   assign next_code = CHAN_COMMON_I ? CODE_CONV_HALF : CODE_SEL_I;

   // Interval timer, one start per interval
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tmr <= '0;
      end else if (accept) begin
         tmr <= TW'(TTI_BASE_CYC) << TTI_SEL_I;
      end else if (tmr != '0) begin
         tmr <= tmr - 1'b1;
      end
   end

   // Latched configuration for the interval
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         code    <= CODE_NONE;
         par_len <= '0;
         poly    <= '0;
         mask    <= '0;
         a_len   <= '0;
         b_len   <= '0;
         x_len   <= '0;
         z_max   <= '0;
         z_unlim <= 1'b1;
      end else if (accept) begin
         code  <= next_code;
         a_len <= XW'(BLK_LEN_I);
         case (CRC_SEL_I)
            CRC_24: begin
               par_len <= `TCS_LEN24;
               poly    <= `TCS_POLY24;
               mask    <= `TCS_MASK24;
            end
            CRC_16: begin
               par_len <= `TCS_LEN16;
               poly    <= `TCS_POLY16;
               mask    <= `TCS_MASK16;
            end
            CRC_12: begin
               par_len <= `TCS_LEN12;
               poly    <= `TCS_POLY12;
               mask    <= `TCS_MASK12;
            end
            CRC_8: begin
               par_len <= `TCS_LEN8;
               poly    <= `TCS_POLY8;
               mask    <= `TCS_MASK8;
            end
            default: begin
               par_len <= '0;
               poly    <= '0;
               mask    <= '0;
            end
         endcase
         z_unlim <= (next_code == CODE_NONE);
         z_max   <= (next_code == CODE_TURBO) ? `TCS_ZMAX_TURBO : `TCS_ZMAX_CONV;
      end else if (state == ST_CNT_C && acc == '0 && c_num == '0) begin
         // Joined length, one cycle after latching
         b_len <= a_len + XW'(par_len);
         x_len <= (a_len + XW'(par_len)) * XW'(BLK_CNT_I);
      end
   end

   // Sequencing and segment sizing
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state <= ST_IDLE;
         c_num <= '0;
         k_len <= '0;
         acc   <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (accept) begin
                  state <= ST_CNT_C;
                  c_num <= '0;
                  acc   <= '0;
                  busy  <= 1'b1;
               end
            end
            ST_CNT_C: begin
               if (acc == '0 && c_num == '0) begin
                  c_num <= XW'(1);
                  acc   <= z_max;
               end else if (x_len == '0) begin
                  state <= ST_IDLE;
                  busy  <= 1'b0;
                  done  <= 1'b1;
               end else if (z_unlim || acc >= x_len) begin
                  state <= ST_CNT_K;
                  k_len <= '0;
                  acc   <= '0;
               end else begin
                  c_num <= c_num + 1'b1;
                  acc   <= acc + z_max;
               end
            end
            ST_CNT_K: begin
               if (acc >= x_len) begin
                  state <= ST_RUN;
               end else begin
                  k_len <= k_len + 1'b1;
                  acc   <= acc + c_num;
               end
            end
            default: begin
               if (emit_last && last_bit) begin
                  state <= ST_IDLE;
                  busy  <= 1'b0;
                  done  <= 1'b1;
               end
            end
         endcase
      end
   end

   // Source selection for the next encoder input bit
   assign conv      = (code == CODE_CONV_HALF) || (code == CODE_CONV_THIRD);
   assign tail      = conv ? `TCS_TAIL_LEN : '0;
   assign in_block  = cb_pos < k_len;
   assign in_cat    = in_block && cat_pos < x_len;
   assign want_data = in_cat && blk_bit < a_len;
   assign fetch_go  = state == ST_RUN && !have_bit && (!want_data || (din_rdy && DIN_VALID_I));
   assign fetch_bit = want_data ? DIN_I : (in_cat ? crc[0] : 1'b0);
   assign cb_end    = cb_pos == k_len + tail - 1'b1;

   // Input handshake, raised only while a data bit is needed
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         din_rdy <= 1'b0;
      end else if (fetch_go) begin
         din_rdy <= 1'b0;
      end else if (state == ST_RUN && !have_bit && want_data) begin
         din_rdy <= 1'b1;
      end
   end

   // Bit position counters across blocks
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cb_pos   <= '0;
         cb_num   <= '0;
         cat_pos  <= '0;
         blk_bit  <= '0;
         last_bit <= 1'b0;
      end else if (state == ST_CNT_K) begin
         cb_pos   <= '0;
         cb_num   <= '0;
         cat_pos  <= '0;
         blk_bit  <= '0;
         last_bit <= 1'b0;
      end else if (fetch_go) begin
         last_bit <= cb_end && cb_num == c_num - 1'b1;
         if (in_cat) begin
            cat_pos <= cat_pos + 1'b1;
            blk_bit <= (blk_bit == b_len - 1'b1) ? '0 : blk_bit + 1'b1;
         end
         if (cb_end) begin
            cb_pos <= '0;
            cb_num <= cb_num + 1'b1;
         end else begin
            cb_pos <= cb_pos + 1'b1;
         end
      end
   end

   // Parity register: divide during data, shift out during parity
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         crc <= '0;
      end else if (state != ST_RUN) begin
         crc <= '0;
      end else if (fetch_go && in_cat) begin
         if (want_data) begin
            crc <= ((crc << 1) ^ ((DIN_I ^ crc[par_len - 1'b1]) ? poly : '0)) & mask;
         end else if (blk_bit == b_len - 1'b1) begin
            crc <= '0;
         end else begin
            crc <= crc >> 1;
         end
      end
   end

   // Encoder output selection
   assign taps      = {cur, sr};
   assign n_out     = (code == CODE_CONV_THIRD) ? 2'd3 : (conv ? 2'd2 : 2'd1);
   assign emit      = have_bit && f_ready;
   assign emit_last = emit && sub == n_out - 1'b1;
   always_comb begin
      if (!conv) begin
         enc_bit = cur;
      end else if (sub == 2'd0) begin
         enc_bit = ^(taps & GEN0);
      end else if (sub == 2'd1) begin
         enc_bit = ^(taps & GEN1);
      end else begin
         enc_bit = ^(taps & GEN2);
      end
   end

   // Encoder state: current bit, phase and shift register
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cur      <= 1'b0;
         have_bit <= 1'b0;
         sub      <= '0;
         sr       <= '0;
      end else if (fetch_go) begin
         cur      <= fetch_bit;
         have_bit <= 1'b1;
         sub      <= '0;
         if (cb_pos == '0) begin
            sr <= '0;
         end
      end else if (emit_last) begin
         have_bit <= 1'b0;
         sub      <= '0;
         sr       <= {cur, sr[7:1]};
      end else if (emit) begin
         sub <= sub + 1'b1;
      end
   end

   // Status flops
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         start_rej <= 1'b0;
      end else begin
         start_rej <= START_I && !accept;
      end
   end

   // Output buffer toward rate matching
   tcs_fifo #(
      .W (1),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (MCLK_I),
      .rst_n_i     (RSTN_I),
      .in_data_i   (enc_bit),
      .in_valid_i  (have_bit),
      .in_ready_o  (f_ready),
      .out_data_o  (DOUT_O),
      .out_valid_o (DOUT_VALID_O),
      .out_ready_i (DOUT_READY_I)
   );

   assign DIN_READY_O = din_rdy;
   assign BUSY_O      = busy;
   assign DONE_O      = done;
   assign START_REJ_O = start_rej;
endmodule : tcs_core

// ==== tb/tcs_core_assertions.sv ====
module tcs_core_chk
   import tcs_pkg::*;
(
   // Watched ports
   input wire logic              MCLK_I,
   input wire logic              RSTN_I,
   input wire logic              START_I,
   input wire logic              DIN_VALID_I,
   input wire logic              DIN_READY_O,
   input wire logic              DOUT_O,
   input wire logic              DOUT_VALID_O,
   input wire logic              DOUT_READY_I,
   input wire logic              BUSY_O,
   input wire logic              DONE_O,
   input wire logic              START_REJ_O
);
   timeunit 1ns;
   timeprecision 1ps;

   // Single clock domain
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RSTN_I);

   a_start_while_busy: assert property (START_I && BUSY_O |=> START_REJ_O)
      else $error("start while busy not refused");
   a_busy_cause: assert property ($rose(BUSY_O) |-> $past(START_I))
      else $error("busy rose without start");
   a_rej_cause: assert property (START_REJ_O |-> $past(START_I))
      else $error("refusal without start");
   a_rej_excl: assert property (START_REJ_O |-> !$rose(BUSY_O))
      else $error("start both refused and taken");
   a_done_pulse: assert property (DONE_O |=> !DONE_O)
      else $error("done longer than one cycle");
   a_busy_end: assert property ($fell(BUSY_O) |-> DONE_O || $past(DONE_O))
      else $error("busy fell without done");
   a_din_take: assert property (DIN_VALID_I && DIN_READY_O |=> !DIN_READY_O)
      else $error("data ready held after take");
   a_idle_no_req: assert property (!BUSY_O |-> !DIN_READY_O)
      else $error("data requested while idle");
   a_out_hold: assert property (DOUT_VALID_O && !DOUT_READY_I
      |=> DOUT_VALID_O && $stable(DOUT_O))
      else $error("output changed while stalled");
   a_idle_quiet: assert property (!BUSY_O && !DOUT_VALID_O && !DONE_O && !$past(DONE_O)
      |=> !DOUT_VALID_O)
      else $error("output while idle");
endmodule : tcs_core_chk

bind tcs_core tcs_core_chk i_tcs_core_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
   .START_I(START_I), .DIN_VALID_I(DIN_VALID_I), .DIN_READY_O(DIN_READY_O),
   .DOUT_O(DOUT_O), .DOUT_VALID_O(DOUT_VALID_O), .DOUT_READY_I(DOUT_READY_I),
   .BUSY_O(BUSY_O), .DONE_O(DONE_O), .START_REJ_O(START_REJ_O));

// ==== tb/tcs_mac_model.sv ====
// Data source standing in for the upper layer
module tcs_mac_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Pacing
   input  wire logic slow_i,
   // Bit handshake
   input  wire logic ready_i,
   output logic      din_o,
   output logic      valid_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic q[$];
   logic took;
   logic gap;

   // Queue a bit, blocks in order, first bit first
   task automatic push(input logic b);
      q.push_back(b);
   endtask : push

   // Handshake seen at the sampling edge
   always @(posedge clk_i) begin
      took <= valid_o && ready_i;
   end

   // Present, hold until taken, then release with inverted level
   always @(negedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         din_o   <= 1'b0;
         gap     <= 1'b0;
      end else if (took && valid_o) begin
         void'(q.pop_front());
         valid_o <= 1'b0;
         din_o   <= ~din_o;
         gap     <= slow_i;
      end else if (gap) begin
         gap <= 1'b0;
      end else if (q.size() > 0 && !valid_o) begin
         valid_o <= 1'b1;
         din_o   <= q[0];
      end
   end
endmodule : tcs_mac_model

// ==== tb/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tcs_pkg::*;

   logic      clk = 0, rst_n = 0, start = 0, common = 0, dout_rdy = 0, slow = 0;
   tcs_tti_t  transmission_interval = TTI_10;
   tcs_crc_t  crc = CRC_NONE;
   tcs_code_t code = CODE_NONE;
   logic [15:0] blen = '0;
   logic [7:0]  bcnt = '0;
   logic      din, din_v, din_rdy, dout, dout_v, busy, done, rej;
   int        n_mismatch = 0, n_checks = 0, cyc = 0, n = 0, tn = 0;
   logic      q_exp[$], got[$];
   localparam logic [8:0] G0 = 9'h16f, G1 = 9'h1d9, G2 = 9'h127;

   tcs_core #(.TTI_BASE_CYC(40), .GEN0(G0), .GEN1(G1), .GEN2(G2)) i_tcs_core (
      .MCLK_I(clk), .RSTN_I(rst_n), .START_I(start), .TTI_SEL_I(transmission_interval), .CRC_SEL_I(crc),
      .CODE_SEL_I(code), .CHAN_COMMON_I(common), .BLK_LEN_I(blen), .BLK_CNT_I(bcnt),
      .DIN_I(din), .DIN_VALID_I(din_v), .DIN_READY_O(din_rdy), .DOUT_O(dout),
      .DOUT_VALID_O(dout_v), .DOUT_READY_I(dout_rdy), .BUSY_O(busy), .DONE_O(done),
      .START_REJ_O(rej));

   tcs_mac_model i_mac (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .ready_i(din_rdy),
      .din_o(din), .valid_o(din_v));

   // Clock
   initial begin
      forever #5 clk = ~clk;
   end

   // Sink pacing with a long stall to fill the FIFO, and hang watchdog
   always @(negedge clk) begin
      cyc++;
      dout_rdy <= (cyc % 7 > 1) && !(cyc > 300 && cyc < 340);
      if (cyc >= 60000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // Collect coded bits
   always @(posedge clk) begin
      if (rst_n && dout_v && dout_rdy) got.push_back(dout);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Build expected stream, feed the source, run one interval
   task automatic run(input tcs_tti_t t, input tcs_crc_t c, input tcs_code_t k,
                      input logic cm, input int a, input int m);
      int L, X, C, K, Z, tl, w;
      logic [23:0] r, poly;
      logic [7:0]  sr;
      logic        b, fb, ok;
      tcs_code_t   ke;
      logic        xs[$];
      L = 0;
      poly = '0;
      case (c)
         CRC_8:  begin L = 8;  poly = 24'h00009b; end
         CRC_12: begin L = 12; poly = 24'h00080f; end
         CRC_16: begin L = 16; poly = 24'h001021; end
         CRC_24: begin L = 24; poly = 24'h800063; end
         default: L = 0;
      endcase
      for (int mi = 0; mi < m; mi++) begin
         r = '0;
         for (int ai = 0; ai < a; ai++) begin
            b = ((n * 7 + n / 3) % 5) < 2;
            n++;
            i_mac.push(b);
            xs.push_back(b);
            fb = (L > 0) ? b ^ r[L-1] : 1'b0;
            r = r << 1;
            if (fb) r = r ^ poly;
         end
         for (int j = 0; j < L; j++) xs.push_back(r[j]);
      end
      ke = cm ? CODE_CONV_HALF : k;
      Z = (ke == CODE_TURBO) ? 5114 : 504;
      X = xs.size();
      C = 1;
      if (ke != CODE_NONE && X > Z) C = (X + Z - 1) / Z;
      K = (X + C - 1) / C;
      while (xs.size() < C * K) xs.push_back(1'b0);
      tl = (ke == CODE_CONV_HALF || ke == CODE_CONV_THIRD) ? 8 : 0;
      q_exp.delete();
      got.delete();
      for (int ci = 0; ci < C; ci++) begin
         sr = '0;
         for (int j = 0; j < K + tl; j++) begin
            b = (j < K) ? xs[ci * K + j] : 1'b0;
            if (tl > 0) begin
               q_exp.push_back(^(G0 & {b, sr}));
               q_exp.push_back(^(G1 & {b, sr}));
               if (ke == CODE_CONV_THIRD) q_exp.push_back(^(G2 & {b, sr}));
               sr = {b, sr[7:1]};
            end else begin
               q_exp.push_back(b);
            end
         end
      end
      @(negedge clk);
      transmission_interval = t;
      crc = c;
      code = k;
      common = cm;
      blen = 16'(a);
      bcnt = 8'(m);
      ok = 1'b0;
      for (int tr = 0; tr < 100 && !ok; tr++) begin
         @(negedge clk) start = 1'b1;
         @(negedge clk) start = 1'b0;
         ok = busy;
         if (!ok) repeat (20) @(negedge clk);
      end
      check(busy, 1);
      @(negedge clk) start = 1'b1;
      @(negedge clk) start = 1'b0;
      check(rej, 1);
      w = 0;
      while (!done && w < 30000) begin
         @(negedge clk);
         w++;
      end
      check(done, 1);
      w = 0;
      while (got.size() < q_exp.size() && w < 500) begin
         @(negedge clk);
         w++;
      end
      repeat (20) @(negedge clk);
      check(got.size(), q_exp.size());
      for (int i = 0; i < q_exp.size() && i < got.size(); i++)
         check(got[i], q_exp[i]);
      tn++;
      $display("test %0d done, %0d coded bits", tn, got.size());
   endtask : run

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      run(TTI_10, CRC_8, CODE_CONV_HALF, 1'b0, 5, 2);
      run(TTI_20, CRC_16, CODE_CONV_THIRD, 1'b0, 4, 1);
      run(TTI_40, CRC_24, CODE_NONE, 1'b0, 3, 2);
      run(TTI_80, CRC_12, CODE_CONV_THIRD, 1'b1, 6, 1);
      slow = 1'b1;
      run(TTI_10, CRC_NONE, CODE_CONV_HALF, 1'b0, 169, 3);
      run(TTI_20, CRC_8, CODE_TURBO, 1'b0, 10, 1);
      // Empty block set, then a start while the interval still runs
      run(TTI_80, CRC_NONE, CODE_NONE, 1'b0, 0, 2);
      @(negedge clk) start = 1'b1;
      @(negedge clk) start = 1'b0;
      check(rej, 1);
      check(busy, 0);
      tally_and_finish();
   end
endmodule : testbench
